// file: dpct_pkg.sv
// Purpose: Shared constants for the dual prescaled counter/timer block.
// Assumes: Register file addresses are 8 bits wide.
// Notes: Offsets are register file addresses.
package dpct_pkg;
    // ----------------------------------------
    // Register addresses
    // ----------------------------------------
    localparam logic [7:0] DPCT_ADDR_MODE = 8'hF1;
    localparam logic [7:0] DPCT_ADDR_T1_COUNT = 8'hF2;
    localparam logic [7:0] DPCT_ADDR_T1_PRE = 8'hF3;
    localparam logic [7:0] DPCT_ADDR_T0_COUNT = 8'hF4;
    localparam logic [7:0] DPCT_ADDR_T0_PRE = 8'hF5;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int DPCT_MODE_T0_LOAD = 0;
    localparam int DPCT_MODE_T0_EN = 1;
    localparam int DPCT_MODE_T1_LOAD = 2;
    localparam int DPCT_MODE_T1_EN = 3;
    localparam int DPCT_MODE_OUT_LO = 6;
    localparam int DPCT_MODE_OUT_HI = 7;
    localparam int DPCT_PRE_CONT = 0;
    localparam int DPCT_PRE_EXTCLK = 1;
    localparam int DPCT_PRE_MOD_LSB = 2;
    // ----------------------------------------
    // Reset values and read answers
    // ----------------------------------------
    localparam logic [7:0] DPCT_MODE_RST = 8'h00;
    localparam logic [7:0] DPCT_PRE_RST = 8'h00;
    localparam logic [7:0] DPCT_COUNT_RST = 8'h00;
    localparam logic [7:0] DPCT_PRE_READ = 8'hFF;
    localparam logic [7:0] DPCT_UNMAPPED_READ = 8'h00;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int DPCT_TCLK_DIV = 4;
    // Output selection codes on mode bits 7:6
    typedef enum logic [1:0] {
        DPCT_OUT_OFF = 2'b00,
        DPCT_OUT_T0 = 2'b01,
        DPCT_OUT_T1 = 2'b10,
        DPCT_OUT_CLK = 2'b11
    } dpct_out_sel_t;
endpackage

// file: dpct_timer.sv
// Purpose: Two 8-bit down-counting timers, each behind a 6-bit prescaler.
// Assumes: Processor register file port on clk; pins are asynchronous.
// Notes: Timer clock is clk divided by four as a one-cycle enable.
//
// What this block does
// - Two independent 8-bit down counters, each fed by its own 6-bit prescaler.
// - At end of count a timer halts at zero or reloads, per mode.
// - Timer zero, and timer one unless it selects the pin, run from the internal clock divided by four.
// - Timer one may count the external input pin when selected.
// - Output pin shows timer zero, timer one or clock; toggles at end unless a mode write falls in that cycle.
// - Prescaler registers are write-only and read back as all ones.
// - Prescaler bits 7:2 hold the modulus reloaded into the prescaler.
// - Low prescaler bits choose counting mode and timer one clock source.
// - Prescaler bit 0: zero single pass, one continuous reload.
// - Timer address writes initial value, reads live count; zero means 256.
// - Load bits 0 and 2 copy held values into the down counters.
// - Load bits clear themselves on the next clock.
// - Load while running keeps running and restarts from the new values.
// - Timers count only while enable bits 1 and 3 are set.
// - First decrement four clocks after enable; external clock next period.
// - Load and enable may be set together to load and start.
// - Holding registers accept writes anytime without disturbing counting.
// - Both prescaler and timer at end raise that timer's request.
// - Prescaler reloads at end, rests at zero only with a zero modulus or before a load, carries once.
`timescale 1ns/100ps
module dpct_timer #(
    parameter int CNT_W = 8,
    parameter int PRE_W = 6
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic port3_line1,
    output logic port3_line6,
    output logic port3_line6_oe_n,
    output logic timer_zero_irq,
    output logic timer_one_irq
);
    import dpct_pkg::*;

    typedef struct packed {
        logic [7:0] mode;
        logic [1:0][7:0] pre_hold;
        logic [1:0][7:0] cnt_hold;
        logic [1:0][PRE_W-1:0] pre_cnt;
        logic [1:0][CNT_W-1:0] cnt;
        logic [1:0] run;
        logic [1:0] done;
        logic [1:0] irq;
        logic [1:0] div;
        logic tout;
        logic clk_half;
        logic tin_s1;
        logic tin_s2;
        logic tin_s3;
        logic [7:0] rdata;
    } dpct_state_t;

    dpct_state_t st_q;
    dpct_state_t st_d;

    logic tclk_en;
    logic tin_fall;
    logic [1:0] tick;
    logic [1:0] pre_end;
    logic [1:0] cnt_end;
    logic [1:0] load;
    logic [1:0] en;
    logic [1:0] wr_pre;
    logic [1:0] wr_cnt;
    logic [1:0] cont;
    dpct_out_sel_t out_sel;

    // ----------------------------------------
    // Timer clock and pin edge
    // ----------------------------------------
    assign tclk_en = (st_q.div == 2'(DPCT_TCLK_DIV - 1));
    // Third stage only feeds the edge detector, after the synchroniser
    assign tin_fall = st_q.tin_s3 & ~st_q.tin_s2;
    assign load[0] = st_q.mode[DPCT_MODE_T0_LOAD];
    assign load[1] = st_q.mode[DPCT_MODE_T1_LOAD];
    assign en[0] = st_q.mode[DPCT_MODE_T0_EN];
    assign en[1] = st_q.mode[DPCT_MODE_T1_EN];
    assign out_sel = dpct_out_sel_t'(st_q.mode[DPCT_MODE_OUT_HI:DPCT_MODE_OUT_LO]);
    assign wr_pre[0] = reg_wr && (reg_addr == DPCT_ADDR_T0_PRE);
    assign wr_pre[1] = reg_wr && (reg_addr == DPCT_ADDR_T1_PRE);
    assign wr_cnt[0] = reg_wr && (reg_addr == DPCT_ADDR_T0_COUNT);
    assign wr_cnt[1] = reg_wr && (reg_addr == DPCT_ADDR_T1_COUNT);

    // ----------------------------------------
    // Per timer datapath terms
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_tmr
            assign cont[gi] = st_q.pre_hold[gi][DPCT_PRE_CONT];
            if (gi == 1) begin : g_src
                // Timer one picks the pin or the divided clock
                assign tick[gi] = st_q.pre_hold[gi][DPCT_PRE_EXTCLK]
                    ? tin_fall : tclk_en;
            end else begin : g_int
                assign tick[gi] = tclk_en;
            end
            // Prescaler end of count at one: value is zero only with a zero modulus or before a load
            assign pre_end[gi] = (st_q.pre_cnt[gi] == PRE_W'(1));
            assign cnt_end[gi] = (st_q.cnt[gi] == CNT_W'(1));
        end
    endgenerate

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.div = st_q.div + 2'd1;
        st_d.clk_half = ~st_q.clk_half;
        st_d.tin_s1 = port3_line1;
        st_d.tin_s2 = st_q.tin_s1;
        st_d.tin_s3 = st_q.tin_s2;
        st_d.irq = 2'b00;
        // Load bits clear on the next clock
        st_d.mode[DPCT_MODE_T0_LOAD] = 1'b0;
        st_d.mode[DPCT_MODE_T1_LOAD] = 1'b0;
        for (int i = 0; i < 2; i++) begin
            if (load[i]) begin
                // Retrigger: running state untouched
                st_d.pre_cnt[i] = st_q.pre_hold[i][7:DPCT_PRE_MOD_LSB];
                st_d.cnt[i] = st_q.cnt_hold[i];
                st_d.done[i] = 1'b0;
            end else if (en[i] && !st_q.done[i] && tick[i]) begin
                if (pre_end[i]) begin
                    st_d.pre_cnt[i] = st_q.pre_hold[i][7:DPCT_PRE_MOD_LSB];
                    if (cnt_end[i]) begin
                        st_d.irq[i] = 1'b1;
                        if (cont[i]) begin
                            st_d.cnt[i] = st_q.cnt_hold[i];
                        end else begin
                            st_d.cnt[i] = '0;
                            st_d.done[i] = 1'b1;
                        end
                    end else begin
                        // Zero wraps to 255, giving 256 counts
                        st_d.cnt[i] = st_q.cnt[i] - CNT_W'(1);
                    end
                end else begin
                    st_d.pre_cnt[i] = st_q.pre_cnt[i] - PRE_W'(1);
                end
            end
            // Holding writes never touch the live counters
            if (wr_pre[i]) begin
                st_d.pre_hold[i] = reg_wdata;
            end
            if (wr_cnt[i]) begin
                st_d.cnt_hold[i] = reg_wdata;
            end
        end
        if (reg_wr && (reg_addr == DPCT_ADDR_MODE)) begin
            st_d.mode = reg_wdata;
            // Realign divider so first internal decrement is four clocks out
            // Load with enable restarts the phase like a fresh start
            if ((reg_wdata[DPCT_MODE_T0_EN] &&
                 (!en[0] || reg_wdata[DPCT_MODE_T0_LOAD])) ||
                (reg_wdata[DPCT_MODE_T1_EN] &&
                 (!en[1] || reg_wdata[DPCT_MODE_T1_LOAD]))) begin
                st_d.div = 2'd0;
            end
            if (reg_wdata[DPCT_MODE_T0_LOAD] || reg_wdata[DPCT_MODE_T1_LOAD]) begin
                st_d.tout = 1'b1;
            end
        end else if ((out_sel == DPCT_OUT_T0 && st_q.irq[0]) ||
                     (out_sel == DPCT_OUT_T1 && st_q.irq[1])) begin
            st_d.tout = ~st_q.tout;
        end
        // Read answer, registered for one cycle latency
        st_d.rdata = DPCT_UNMAPPED_READ;
        if (reg_rd) begin
            unique case (reg_addr)
                DPCT_ADDR_MODE: st_d.rdata = st_d.mode;
                DPCT_ADDR_T0_COUNT: st_d.rdata = st_q.cnt[0];
                DPCT_ADDR_T1_COUNT: st_d.rdata = st_q.cnt[1];
                DPCT_ADDR_T0_PRE: st_d.rdata = DPCT_PRE_READ;
                DPCT_ADDR_T1_PRE: st_d.rdata = DPCT_PRE_READ;
                default: st_d.rdata = DPCT_UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= '0;
            st_q.mode <= DPCT_MODE_RST;
            st_q.pre_hold <= {2{DPCT_PRE_RST}};
            st_q.cnt_hold <= {2{DPCT_COUNT_RST}};
            st_q.tout <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata = st_q.rdata;
    assign timer_zero_irq = st_q.irq[0];
    assign timer_one_irq = st_q.irq[1];
    // Clock output is clk halved; true clk cannot leave through a flop
    assign port3_line6 = (out_sel == DPCT_OUT_CLK) ? st_q.clk_half
        : st_q.tout;
    assign port3_line6_oe_n = (out_sel == DPCT_OUT_OFF);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_load_clear;
        @(posedge clk) disable iff (srst)
        load[0] |=> !load[0] || $past(reg_wr);
    endproperty
    a_load_clear: assert property (p_load_clear)
        else $error("load bit did not clear");

    property p_load_copy;
        @(posedge clk) disable iff (srst)
        load[0] |=> st_q.cnt[0] == $past(st_q.cnt_hold[0]);
    endproperty
    a_load_copy: assert property (p_load_copy)
        else $error("load did not copy count");

    property p_pre_read;
        @(posedge clk) disable iff (srst)
        reg_rd && reg_addr == DPCT_ADDR_T0_PRE |=> reg_rdata == 8'hFF;
    endproperty
    a_pre_read: assert property (p_pre_read)
        else $error("prescaler read not all ones");

    property p_idle;
        @(posedge clk) disable iff (srst)
        !en[0] && !load[0] |=> st_q.cnt[0] == $past(st_q.cnt[0]);
    endproperty
    a_idle: assert property (p_idle)
        else $error("disabled timer moved");

    property p_pre_nz;
        @(posedge clk) disable iff (srst)
        en[0] && !load[0] && $past(!load[0]) && st_q.pre_hold[0][7:2] != 0
        |-> st_q.pre_cnt[0] != 0;
    endproperty
    a_pre_nz: assert property (p_pre_nz)
        else $error("prescaler rested at zero");

    property p_irq_end;
        @(posedge clk) disable iff (srst)
        timer_zero_irq |-> $past(pre_end[0] && cnt_end[0] && tclk_en);
    endproperty
    a_irq_end: assert property (p_irq_end)
        else $error("request without end of count");

    property p_single;
        @(posedge clk) disable iff (srst)
        timer_zero_irq && !$past(cont[0]) && !$past(load[0])
        |-> st_q.cnt[0] == 0;
    endproperty
    a_single: assert property (p_single)
        else $error("single pass did not stop at zero");

    property p_toggle;
        @(posedge clk) disable iff (srst)
        out_sel == DPCT_OUT_T0 && timer_zero_irq && !reg_wr
        ##1 out_sel == DPCT_OUT_T0 |-> port3_line6 != $past(port3_line6);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("output did not toggle");

    property p_div;
        @(posedge clk) disable iff (srst)
        tclk_en && !reg_wr |=> !tclk_en [*3];
    endproperty
    a_div: assert property (p_div)
        else $error("timer clock not divide by four");

    property p_load_clear1;
        @(posedge clk) disable iff (srst)
        load[1] |=> !load[1] || $past(reg_wr);
    endproperty
    a_load_clear1: assert property (p_load_clear1)
        else $error("timer one load bit did not clear");

    property p_load_copy1;
        @(posedge clk) disable iff (srst)
        load[1] |=> st_q.cnt[1] == $past(st_q.cnt_hold[1]);
    endproperty
    a_load_copy1: assert property (p_load_copy1)
        else $error("timer one load did not copy count");

    property p_pre_read1;
        @(posedge clk) disable iff (srst)
        reg_rd && reg_addr == DPCT_ADDR_T1_PRE |=> reg_rdata == DPCT_PRE_READ;
    endproperty
    a_pre_read1: assert property (p_pre_read1)
        else $error("timer one prescaler read not all ones");

    property p_idle1;
        @(posedge clk) disable iff (srst)
        !en[1] && !load[1] |=> st_q.cnt[1] == $past(st_q.cnt[1]);
    endproperty
    a_idle1: assert property (p_idle1)
        else $error("disabled timer one moved");

    property p_irq1_end;
        @(posedge clk) disable iff (srst)
        timer_one_irq |-> $past(pre_end[1] && cnt_end[1] && tick[1]);
    endproperty
    a_irq1_end: assert property (p_irq1_end)
        else $error("timer one request without end of count");

    property p_hold_write;
        @(posedge clk) disable iff (srst)
        wr_cnt[0] |=> st_q.cnt_hold[0] == $past(reg_wdata);
    endproperty
    a_hold_write: assert property (p_hold_write)
        else $error("count holding write lost");

    property p_rd_idle;
        @(posedge clk) disable iff (srst)
        !reg_rd |=> reg_rdata == DPCT_UNMAPPED_READ;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data without read strobe");

    property p_pre_reload;
        @(posedge clk) disable iff (srst)
        en[0] && !load[0] && !st_q.done[0] && tick[0] && pre_end[0]
        |=> st_q.pre_cnt[0] == $past(st_q.pre_hold[0][7:2]);
    endproperty
    a_pre_reload: assert property (p_pre_reload)
        else $error("prescaler did not reload modulus");

    property p_tout_init;
        @(posedge clk) disable iff (srst)
        reg_wr && reg_addr == DPCT_ADDR_MODE && reg_wdata[DPCT_MODE_T0_LOAD]
        |=> st_q.tout;
    endproperty
    a_tout_init: assert property (p_tout_init)
        else $error("load did not set output high");
endmodule

// file: dpct_host.sv
// Purpose: Processor-side model of the register port and the timer input pin.
// Assumes: Requests launch at the falling edge, held over one rising edge.
// Notes: Idle address and data wander; stale values are never trusted.
`timescale 1ns/100ps
module dpct_host (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    output logic port3_line1
);
    initial begin
        port3_line1 = 1'b1;
        idle();
    end
    task automatic idle();
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'($urandom);
        reg_wdata = 8'($urandom);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        idle();
    endtask
    // Data is registered, so it is taken one cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        idle();
        d = reg_rdata;
    endtask
    // Long pulse so the synchroniser sees every falling edge
    task automatic ext_pulse();
        repeat (4) @(negedge clk);
        port3_line1 = 1'b0;
        repeat (4) @(negedge clk);
        port3_line1 = 1'b1;
    endtask
endmodule

// file: dpct_timer_test.sv
// Purpose: Self-checking bench for the dual prescaled timer.
// Assumes: Host model drives the register port at the falling edge.
// Notes: Intervals are measured in clocks between falling edges.
`timescale 1ns/100ps
module dpct_timer_test;
    import dpct_pkg::*;
    logic clk, srst, p1, p6, oe_n, wr, rd;
    logic [1:0] irq;
    logic [7:0] a, wd, rdat;
    int failures = 0;
    int tests_run = 0;
    int irq_t[2][$];
    dpct_timer i_dpct_timer (.clk(clk), .srst(srst), .reg_addr(a),
        .reg_wr(wr), .reg_rd(rd), .reg_wdata(wd), .reg_rdata(rdat),
        .port3_line1(p1), .port3_line6(p6), .port3_line6_oe_n(oe_n),
        .timer_zero_irq(irq[0]), .timer_one_irq(irq[1]));
    dpct_host i_dpct_host (.clk(clk), .reg_addr(a), .reg_wr(wr),
        .reg_rd(rd), .reg_wdata(wd), .reg_rdata(rdat), .port3_line1(p1));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(negedge clk) begin
        for (int k = 0; k < 2; k++)
            if (irq[k] === 1'b1) irq_t[k].push_back(int'($time) / 4);
    end
    function automatic int ex(input int v);
        return (v == 0) ? 256 : v;
    endfunction
    task automatic chk8(input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: exp %h got %h", $time, e, g);
        end
    endtask
    task automatic chkn(input int e, input int g);
        tests_run++;
        if (g != e) begin
            failures++;
            $display("unexpected at %0t: exp %h got %h", $time, e, g);
        end
    endtask
    task automatic rdchk(input logic [7:0] ad, input logic [7:0] e);
        logic [7:0] d;
        i_dpct_host.rd(ad, d);
        chk8(e, d);
    endtask
    task automatic wait_irq(input int k, output int t);
        int n;
        n = 0;
        while (irq_t[k].size() == 0 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        t = 0;
        if (irq_t[k].size() == 0) failures++;
        else t = irq_t[k].pop_front();
    endtask
    // Continuous run, holding-register update mid-count, then retrigger
    task automatic run_timer(input int k, input int p, input int v,
                             input int v2);
        int t, t2, s;
        logic [7:0] md, ca;
        md = k ? 8'h8C : 8'h43;
        ca = k ? DPCT_ADDR_T1_COUNT : DPCT_ADDR_T0_COUNT;
        irq_t[k].delete();
        i_dpct_host.wr(k ? DPCT_ADDR_T1_PRE : DPCT_ADDR_T0_PRE,
                       {p[5:0], 2'b01});
        i_dpct_host.wr(ca, v[7:0]);
        i_dpct_host.wr(DPCT_ADDR_MODE, md);
        s = int'($time) / 4;
        wait_irq(k, t);
        chkn(4 * p * ex(v), t - s);
        repeat (2) @(negedge clk);
        chk8(8'h00, {7'h0, p6});
        chk8(8'h00, {7'h0, oe_n});
        i_dpct_host.wr(ca, v2[7:0]);
        wait_irq(k, t2);
        chkn(4 * p * ex(v), t2 - t);
        repeat (2) @(negedge clk);
        chk8(8'h01, {7'h0, p6});
        wait_irq(k, t);
        chkn(4 * p * ex(v2), t - t2);
        repeat (5) @(negedge clk);
        i_dpct_host.wr(DPCT_ADDR_MODE, md);
        s = int'($time) / 4;
        @(negedge clk);
        irq_t[k].delete();
        wait_irq(k, t);
        chkn(4 * p * ex(v2), t - s);
        i_dpct_host.wr(DPCT_ADDR_MODE, 8'h00);
        $display("continuous run on timer %0d done", k);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #300000;
        failures++;
        report_and_stop();
    end
    initial begin
        int p, v, t, s;
        logic [7:0] r;
        logic b;
        srst = 1'b1;
        void'($urandom(32'hC02B));
        repeat (8) @(negedge clk);
        srst = 1'b0;
        for (int x = 8'hF0; x <= 8'hF6; x++)
            rdchk(x[7:0], (x == 8'hF3 || x == 8'hF5) ? 8'hFF : 8'h00);
        r = 8'($urandom);
        i_dpct_host.wr(DPCT_ADDR_T0_PRE, r);
        i_dpct_host.wr(DPCT_ADDR_T1_PRE, r);
        i_dpct_host.wr(DPCT_ADDR_T0_COUNT, r);
        i_dpct_host.wr(DPCT_ADDR_T1_COUNT, ~r);
        i_dpct_host.wr(DPCT_ADDR_MODE, 8'h05);
        rdchk(DPCT_ADDR_MODE, 8'h00);
        rdchk(DPCT_ADDR_T1_PRE, 8'hFF);
        repeat (40) @(negedge clk);
        rdchk(DPCT_ADDR_T0_COUNT, r);
        rdchk(DPCT_ADDR_T1_COUNT, ~r);
        $display("register access test done");
        run_timer(0, 1, 0, 2);
        for (int i = 0; i < 2; i++)
            run_timer(i, 1 + $urandom % 3, 2 + $urandom % 4, 1 + $urandom % 5);
        p = 1 + $urandom % 3;
        v = 1 + $urandom % 4;
        i_dpct_host.wr(DPCT_ADDR_T0_PRE, {p[5:0], 2'b00});
        i_dpct_host.wr(DPCT_ADDR_T0_COUNT, v[7:0]);
        i_dpct_host.wr(DPCT_ADDR_MODE, 8'h03);
        s = int'($time) / 4;
        wait_irq(0, t);
        chkn(4 * p * v, t - s);
        rdchk(DPCT_ADDR_T0_COUNT, 8'h00);
        repeat (8 * p * v + 8) @(negedge clk);
        chkn(0, irq_t[0].size());
        $display("single pass test done");
        p = 1 + $urandom % 2;
        v = 1 + $urandom % 3;
        i_dpct_host.wr(DPCT_ADDR_MODE, 8'h00);
        i_dpct_host.wr(DPCT_ADDR_T1_PRE, {p[5:0], 2'b10});
        i_dpct_host.wr(DPCT_ADDR_T1_COUNT, v[7:0]);
        i_dpct_host.wr(DPCT_ADDR_MODE, 8'h0C);
        irq_t[1].delete();
        repeat (p * v - 1) i_dpct_host.ext_pulse();
        repeat (8) @(negedge clk);
        chkn(0, irq_t[1].size());
        i_dpct_host.ext_pulse();
        repeat (8) @(negedge clk);
        chkn(1, irq_t[1].size());
        $display("external clock test done");
        i_dpct_host.wr(DPCT_ADDR_MODE, 8'hC0);
        @(negedge clk);
        b = p6;
        @(negedge clk);
        chk8({7'h0, ~b}, {7'h0, p6});
        chk8(8'h00, {7'h0, oe_n});
        i_dpct_host.wr(DPCT_ADDR_MODE, 8'h00);
        chk8(8'h01, {7'h0, oe_n});
        $display("clock output test done");
        report_and_stop();
    end
endmodule
